// >>> pevg_pkg.sv
// Constants and types for the position and emergency video generator.
// Assumes a single 250 MHz clock and an AHB-Lite register port.
`default_nettype none
package pevg_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  // Clock rate in MHz
  localparam int unsigned CLK_MHZ = 250;
  // Position pulse delay, ns
  localparam int unsigned POS_DELAY_NS = 24650;
  // Least emergency gate, ns
  localparam int unsigned GATE_MIN_NS = 14000;
  // Longest-style delay rounds down
  localparam int unsigned POS_DELAY_CYC = POS_DELAY_NS * CLK_MHZ / 1000;
  // Least gate rounds up
  localparam int unsigned GATE_MIN_CYC = (GATE_MIN_NS * CLK_MHZ + 999) / 1000;
  // Timer width
  localparam int CNT_W = 16;
  // Gate floor at counter width
  localparam logic [CNT_W-1:0] GATE_MIN = CNT_W'(GATE_MIN_CYC);
  // ==========================================================
  // Register map (byte offsets)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GATE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_ECNT = 8'h0C;
  // Control field positions
  localparam int CTRL_MODE = 0;
  localparam int CTRL_POSOFF = 2;
  localparam int CTRL_EMER = 3;
  localparam int CTRL_BRK = 4;
  // Mode codes
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h2;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ==========================================================
  // Types
  // ==========================================================
  // Emergency window state
  typedef enum logic [1:0] {EMER_IDLE, EMER_GATE, EMER_ARMED} pevg_emer_t;
  // Video inputs from the decoder
  typedef struct packed {
    logic decoded_video;
    logic reply_video;
    logic bracket_first_pulse;
    logic bracket_second_pulse;
  } pevg_vid_in_t;
  // Triggers to the display pulse generators
  typedef struct packed {
    logic short_trig;
    logic long_trig;
    logic gated_bracket_video;
  } pevg_disp_t;
  // Software control
  typedef struct packed {
    logic [1:0] mode;
    logic pos_off;
    logic emer_en;
    logic brk_sel;
  } pevg_ctrl_t;
  // Whole module state
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    pevg_ctrl_t ctrl;
    logic [CNT_W-1:0] gate_cyc;
    logic [CNT_W-1:0] pos_cnt;
    logic [CNT_W-1:0] gate_cnt;
    pevg_emer_t emer;
    logic [7:0] ecnt;
    logic wr_pend;
    logic [7:0] waddr;
    logic [31:0] hrdata;
    logic hreadyout;
    pevg_disp_t disp;
  } pevg_state_t;
endpackage : pevg_pkg
`default_nettype wire

// >>> pevg_top.sv
// Position and emergency video generator with an AHB-Lite register slave.
// Assumes decoder pulses arrive asynchronously and last several clocks.
//
// How it works
// - Position trigger needs raw and decoded coincident
// - Trigger starts 24.65 us delay and 14 us gate
// - Position pulse emitted when delay ends
// - Mode 1 position-off suppresses generated pulse
// - Decoded, position, emergency ORed to both generators
// - Bracket pair detected whenever both brackets present
// - Bracket-pair video follows each bracket set
// - Emergency pulse needs bracket, armed window, enable
// - Window armed at gate end until restart
// - Gate started by trigger or emergency feedback
// - Each emergency pulse restarts the gate
// - Emergency and position overlap is harmless
// - Emergency logic idles when brackets stop
// - Gate width adjustable upward from 14 us
// - Emergency enabled only by selector switch
// - Bracket selector blocks or passes bracket video
// - Bracket mode displays any answered interrogation
// - Decoded video means clean code match
`default_nettype none
module pevg_top #(
  // Position delay in clocks, shortenable for simulation
  parameter int unsigned POS_DELAY = pevg_pkg::POS_DELAY_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire pevg_pkg::pevg_vid_in_t vid_in,
  output pevg_pkg::pevg_disp_t disp
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Counter must hold the delay, and the delay must be at least two
  if (POS_DELAY < 2 || POS_DELAY >= (1 << pevg_pkg::CNT_W))
  begin : g_bad_delay
    $error("POS_DELAY out of range");
  end

  // Gate floor must fit the timer, or clamping would wrap
  if (pevg_pkg::GATE_MIN_CYC >= (1 << pevg_pkg::CNT_W))
  begin : g_bad_gate
    $error("GATE_MIN_CYC does not fit CNT_W");
  end

  // ==========================================================
  // State
  // ==========================================================
  // Registered state
  pevg_pkg::pevg_state_t s_q;
  // Next state
  pevg_pkg::pevg_state_t s_d;
  // Position delay at counter width
  localparam logic [pevg_pkg::CNT_W-1:0] POS_LOAD =
    pevg_pkg::CNT_W'(POS_DELAY);
  // Counter constant one, sized from the counter width
  localparam logic [pevg_pkg::CNT_W-1:0] ONE = {{(pevg_pkg::CNT_W-1){1'h0}}, 1'h1};
  // Counter zero
  localparam logic [pevg_pkg::CNT_W-1:0] ZERO = '0;
  // Status word bit positions
  localparam int STAT_POS = 0;
  localparam int STAT_GATE = 1;
  localparam int STAT_ARMED = 2;

  // Pin sample vector
  logic [3:0] pins;
  assign pins = vid_in;

  // Decode helpers
  logic dec_lvl;
  logic trig;
  logic br_pair;
  logic pos_fire;
  logic emer_video;
  logic gate_start;
  logic gate_end;
  logic addr_ok;
  logic [7:0] aofs;
  logic [31:0] rd_val;
  logic [pevg_pkg::CNT_W-1:0] wgate;
  // Synchronised pins by name, this clock and the one before
  pevg_pkg::pevg_vid_in_t now_v;
  pevg_pkg::pevg_vid_in_t was_v;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // Whole block computed in one pass
  always_comb
  begin
    s_d = s_q;
    // Two-flop synchronisers, then edge history
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    // Name the pins so no bit index is hard coded
    now_v = pevg_pkg::pevg_vid_in_t'(s_q.sync2);
    was_v = pevg_pkg::pevg_vid_in_t'(s_q.prev);

    // clean match only
    // Decoded video is trusted as already free of kill slots
    dec_lvl = now_v.decoded_video;

    trig = (now_v.decoded_video & now_v.reply_video) &
      ~(was_v.decoded_video & was_v.reply_video);

    // one strobe per set
    // Not gated by any code setting, so any reply frames it
    // The decoder already spaces each pair one frame period on
    br_pair = (now_v.bracket_first_pulse & now_v.bracket_second_pulse) &
      ~(was_v.bracket_first_pulse & was_v.bracket_second_pulse);

    // fire at delay end
    // Retrigger restarts; last trigger wins
    pos_fire = 1'b0;
    if (trig)
    begin
      s_d.pos_cnt = POS_LOAD;
    end
    else if (s_q.pos_cnt != ZERO)
    begin
      s_d.pos_cnt = s_q.pos_cnt - ONE;
      if (s_q.pos_cnt == ONE)
      begin
        pos_fire = 1'b1;
      end
    end

    if (s_q.ctrl.mode == pevg_pkg::MODE_1 && s_q.ctrl.pos_off)
    begin
      pos_fire = 1'b0;
    end

    emer_video = br_pair & (s_q.emer == pevg_pkg::EMER_ARMED) &
      s_q.ctrl.emer_en;

    // each pulse restarts
    // Trigger and feedback in one clock load the gate only once
    gate_start = trig | emer_video;

    gate_end = 1'b0;
    if (gate_start)
    begin
      s_d.gate_cnt = s_q.gate_cyc;
    end
    else if (s_q.gate_cnt != ZERO)
    begin
      s_d.gate_cnt = s_q.gate_cnt - ONE;
      if (s_q.gate_cnt == ONE)
      begin
        gate_end = 1'b1;
      end
    end

    // idle when brackets stop
    // Armed window waits for a start; with no more brackets it stays
    // quiet, so output falls silent without a timeout
    case (s_q.emer)
      pevg_pkg::EMER_IDLE:
      begin
        if (gate_start)
        begin
          s_d.emer = pevg_pkg::EMER_GATE;
        end
      end
      pevg_pkg::EMER_GATE:
      begin
        if (gate_end)
        begin
          s_d.emer = pevg_pkg::EMER_ARMED;
        end
      end
      pevg_pkg::EMER_ARMED:
      begin
        if (gate_start)
        begin
          s_d.emer = pevg_pkg::EMER_GATE;
        end
      end
      default:
      begin
        s_d.emer = pevg_pkg::EMER_IDLE;
      end
    endcase

    // Emergency pulse count, wraps
    if (emer_video)
    begin
      s_d.ecnt = s_q.ecnt + 8'h01;
    end

    s_d.disp.long_trig = (dec_lvl & ~was_v.decoded_video) | pos_fire | emer_video;
    s_d.disp.gated_bracket_video = br_pair & s_q.ctrl.brk_sel;
    s_d.disp.short_trig = s_d.disp.long_trig | s_d.disp.gated_bracket_video;

    // ========================================================
    // AHB-Lite slave
    // ========================================================
    // Zero wait states; always ready and OKAY
    s_d.hreadyout = 1'b1;
    aofs = haddr[7:0];
    addr_ok = hsel & hready & (htrans == pevg_pkg::HTRANS_NONSEQ);

    // Data-phase write lands here
    wgate = hwdata[pevg_pkg::CNT_W-1:0];
    if (s_q.wr_pend)
    begin
      case (s_q.waddr)
        pevg_pkg::OFS_CTRL:
        begin
          s_d.ctrl.mode = hwdata[pevg_pkg::CTRL_MODE +: 2];
          s_d.ctrl.pos_off = hwdata[pevg_pkg::CTRL_POSOFF];
          s_d.ctrl.emer_en = hwdata[pevg_pkg::CTRL_EMER];
          s_d.ctrl.brk_sel = hwdata[pevg_pkg::CTRL_BRK];
        end
        pevg_pkg::OFS_GATE:
        begin
          // clamp to floor
          // Values under the floor would shorten the window below spec
          s_d.gate_cyc = (wgate < pevg_pkg::GATE_MIN) ? pevg_pkg::GATE_MIN : wgate;
        end
        default:
        begin
          s_d.gate_cyc = s_q.gate_cyc;
        end
      endcase
    end

    // Address phase decode
    s_d.wr_pend = addr_ok & hwrite;
    s_d.waddr = aofs;

    // Read value chosen in address phase
    rd_val = 32'h0000_0000;
    case (aofs)
      pevg_pkg::OFS_CTRL:
      begin
        rd_val[pevg_pkg::CTRL_MODE +: 2] = s_q.ctrl.mode;
        rd_val[pevg_pkg::CTRL_POSOFF] = s_q.ctrl.pos_off;
        rd_val[pevg_pkg::CTRL_EMER] = s_q.ctrl.emer_en;
        rd_val[pevg_pkg::CTRL_BRK] = s_q.ctrl.brk_sel;
      end
      pevg_pkg::OFS_GATE:
      begin
        rd_val[pevg_pkg::CNT_W-1:0] = s_q.gate_cyc;
      end
      pevg_pkg::OFS_STAT:
      begin
        rd_val[STAT_POS] = (s_q.pos_cnt != ZERO);
        rd_val[STAT_GATE] = (s_q.emer == pevg_pkg::EMER_GATE);
        rd_val[STAT_ARMED] = (s_q.emer == pevg_pkg::EMER_ARMED);
      end
      pevg_pkg::OFS_ECNT:
      begin
        rd_val[7:0] = s_q.ecnt;
      end
      default:
      begin
        rd_val = 32'h0000_0000;
      end
    endcase
    if (addr_ok & ~hwrite)
    begin
      s_d.hrdata = rd_val;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Asynchronous reset to constants only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '{
        sync1: 4'h0,
        sync2: 4'h0,
        prev: 4'h0,
        ctrl: '{mode: pevg_pkg::MODE_RST, pos_off: 1'b0,
                emer_en: 1'b0, brk_sel: 1'b0},
        gate_cyc: pevg_pkg::GATE_MIN,
        pos_cnt: ZERO,
        gate_cnt: ZERO,
        emer: pevg_pkg::EMER_IDLE,
        ecnt: 8'h00,
        wr_pend: 1'b0,
        waddr: 8'h00,
        hrdata: 32'h0000_0000,
        hreadyout: 1'b1,
        disp: '{short_trig: 1'b0, long_trig: 1'b0,
                gated_bracket_video: 1'b0}
      };
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // All but hresp straight from flops; response is always OKAY
  assign hreadyout = s_q.hreadyout;
  assign hrdata = s_q.hrdata;
  assign hresp = 1'b0;
  assign disp = s_q.disp;

endmodule : pevg_top
`default_nettype wire

// >>> pevg_asserts.sv
// Checker for the position and emergency video generator.
// Assumes it is bound to pevg_top and sees only its ports.
`default_nettype none
module pevg_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire pevg_pkg::pevg_vid_in_t vid_in,
  input wire pevg_pkg::pevg_disp_t disp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Read address phase accepted
  wire logic rd_take = hsel && hready && htrans == pevg_pkg::HTRANS_NONSEQ && !hwrite;
  // Both bracket slots filled
  wire logic pair = vid_in.bracket_first_pulse && vid_in.bracket_second_pulse;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Sequences
  // ==========================================================
  sequence dec_rise_s;
    $rose(vid_in.decoded_video);
  endsequence
  sequence trig_out_s;
    ##[1:4] disp.long_trig;
  endsequence
  // ==========================================================
  // Properties
  // ==========================================================
  bus_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  zero_wait_a: assert property (hreadyout) else $error("wait state inserted");
  rd_hold_a: assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved");
  dec_out_a: assert property (dec_rise_s |-> trig_out_s) else $error("decoded lost");
  brk_cause_a: assert property (disp.gated_bracket_video |->
    $past(pair, 2) || $past(pair, 3) || $past(pair, 4)) else $error("bracket uncaused");
  brk_short_a: assert property (disp.gated_bracket_video |-> disp.short_trig)
    else $error("bracket not on short");
  long_short_a: assert property (disp.long_trig |-> disp.short_trig)
    else $error("long without short");
  short_cause_a: assert property (disp.short_trig && !disp.gated_bracket_video |->
    disp.long_trig) else $error("short without long");
  brk_strobe_a: assert property (disp.gated_bracket_video |=> !disp.gated_bracket_video)
    else $error("bracket pulse too long");
endmodule : pevg_asserts
bind pevg_top pevg_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .vid_in(vid_in), .disp(disp));
`default_nettype wire

// >>> pevg_partner.sv
// Decoder-side model: turns one-cycle requests into video pulses.
// Assumes requests come at least five clocks apart.
`default_nettype none
module pevg_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] req,
  output var pevg_pkg::pevg_vid_in_t vid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_q; // Lines to raise
  logic [1:0] cnt_q; // Clocks left high
  // ==========================================================
  // Pulse shaping
  // ==========================================================
  // coincident clean pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_q <= 4'h0;
      cnt_q <= 2'h0;
    end
    else if (req != 4'h0)
    begin
      hold_q <= req;
      cnt_q <= 2'h3;
    end
    else if (cnt_q != 2'h0)
      cnt_q <= cnt_q - 2'h1;
  end
  // Released lines fall to their pull-down level
  assign vid_in = pevg_pkg::pevg_vid_in_t'((cnt_q != 2'h0) ? hold_q : 4'h0);
endmodule : pevg_partner
`default_nettype wire

// >>> pevg_top_test.sv
// Self-checking bench for the position and emergency video generator.
// Assumes a zero-wait AHB-Lite slave and the decoder model beside it.
`default_nettype none
module pevg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PD = 40; // Short position delay
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic hreadyout, hresp;
  logic [3:0] req = 4'h0;
  pevg_pkg::pevg_vid_in_t vid_in;
  pevg_pkg::pevg_disp_t disp;
  int num_errors = 0, num_checks = 0, nl = 0, ns = 0, ng = 0, bl, bs, bg;
  pevg_top #(.POS_DELAY(PD)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .vid_in(vid_in), .disp(disp));
  pevg_partner u_dec (.hclk(hclk), .hresetn(hresetn), .req(req), .vid_in(vid_in));
  // ==========================================================
  // Clock, output counters, helpers
  // ==========================================================
  initial forever #2 hclk = ~hclk;
  // Count every trigger the generators would see
  always @(posedge hclk)
  begin
    nl += (disp.long_trig === 1'b1);
    ns += (disp.short_trig === 1'b1);
    ng += (disp.gated_bracket_video === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One single AHB transfer; hold each phase until hready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= pevg_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  // Ask the decoder for one pulse, then let time pass
  task pulse(input logic [3:0] v, input int n);
    bl = nl;
    bs = ns;
    bg = ng;
    @(posedge hclk) req <= v;
    @(posedge hclk) req <= 4'h0;
    repeat (n) @(posedge hclk);
  endtask : pulse
  task cnt(input int l, input int s, input int g);
    chk(32'(nl - bl), 32'(l));
    chk(32'(ns - bs), 32'(s));
    chk(32'(ng - bg), 32'(g));
  endtask : cnt
  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_regs;
    rd(8'h00, 32'h2);
    rd(8'h04, 32'h0DAC);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    ahb(1'b1, 8'h04, 32'h000A);
    rd(8'h04, 32'h0DAC);
    ahb(1'b1, 8'h04, 32'h0DB0);
    rd(8'h04, 32'h0DB0);
    ahb(1'b1, 8'h04, 32'h0DAC);
    ahb(1'b1, 8'h10, 32'hFF);
    rd(8'h10, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // Modes 2, 3 and 1 without position-off, then mode 1 with it
  task t_pos;
    logic [31:0] c [4] = '{32'h2, 32'h3, 32'h1, 32'h5};
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, 8'h00, c[i]);
      pulse(4'h8, PD + 20);
      cnt(1, 1, 0);
      pulse(4'hC, 8);
      rd(8'h08, 32'h3);
      cnt(1, 1, 0);
      repeat (PD) @(posedge hclk);
      cnt(2 - (i / 3), 2 - (i / 3), 0);
    end
    $display("test position done");
  endtask : t_pos
  task t_brk;
    repeat (3500) @(posedge hclk);
    rd(8'h08, 32'h4);
    for (int b = 0; b < 2; b++)
    begin
      ahb(1'b1, 8'h00, 32'h02 | (b << 4));
      pulse(4'h3, 10);
      cnt(0, b, b);
    end
    rd(8'h0C, 32'h0);
    $display("test bracket done");
  endtask : t_brk
  task t_emer;
    ahb(1'b1, 8'h00, 32'h0A);
    pulse(4'hC, 100);
    pulse(4'h3, 10);
    cnt(0, 0, 0);
    repeat (3500) @(posedge hclk);
    for (int k = 1; k < 3; k++)
    begin
      pulse(4'h3, 10);
      cnt(1, 1, 0);
      rd(8'h0C, 32'(k));
      rd(8'h08, 32'h2);
      pulse(4'h3, 10);
      cnt(0, 0, 0);
      repeat (3500) @(posedge hclk);
    end
    pulse(4'h0, 100);
    cnt(0, 0, 0);
    rd(8'h08, 32'h4);
    // Reply, trigger and armed bracket pair in one clock merge into one pulse
    pulse(4'hF, PD + 20);
    cnt(2, 2, 0);
    rd(8'h0C, 32'h3);
    $display("test emergency done");
  endtask : t_emer
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_pos();
    t_brk();
    t_emer();
    end_sim();
  end
  // Run needs about 15000 clocks; allow over three times that
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : pevg_top_test
`default_nettype wire
